// [verilog/tmc_timer.sv]
// Sixteen-bit timer/counter with APB registers
// Functional notes
// - Cs clear counts prescaled instruction cycles
// - Cs set counts external or oscillator rising edges
// - Run bit gates all counting
// - Oscillator enable bit starts/stops oscillator
// - Oscillator and unsync path run in sleep
// - Count runs 0000 to ffff, wraps
// - Wrap sets sticky overflow flag
// - Enable bit gates overflow interrupt
// - Special event match resets counter, starts conversion, except in unsync counter mode
// - Trigger reset never sets overflow flag
// - Counter write beats simultaneous trigger reset
// - Compare value pair acts as period
// - Control bits 7:6 read zero
`timescale 1ns/10ps
`include "tmc_defines.svh"
`default_nettype none
module tmc_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        sleep_mode,
	input  wire logic        external_count_input,
	input  wire logic        crystal_input_pin,
	output logic             crystal_output_pin,
	output logic             crystal_output_oe_n,
	input  wire logic [3:0]  compare_unit_mode_select,
	input  wire logic [15:0] compare_value_pair,
	input  wire logic        adc_enable,
	output logic             conversion_start,
	output logic             special_trigger
);

	// Prescaler mask: all ones ends one divided period
	// A mask keeps the divide test a single compare for every ratio
	function automatic logic [2:0] psc_mask(
		input logic [1:0] sel
	);
		case (sel)
			2'h0:    psc_mask = 3'h0;
			2'h1:    psc_mask = 3'h1;
			2'h2:    psc_mask = 3'h3;
			default: psc_mask = 3'h7;
		endcase
	endfunction : psc_mask

	// True when the bus index selects a register
	// Shared by the decode, the write logic and the checks
	function automatic logic hit(
		input logic [7:0] idx,
		input logic [7:0] want
	);
		hit = (idx == want);
	endfunction : hit

	// All state sits in one struct, so reset and update stay in one place
	tmc_pkg::tmc_state_t s_reg;  // Registered state
	tmc_pkg::tmc_state_t s_next; // Next state

	logic [7:0] idx;      // Register index from bus
	logic       acc;      // Access phase, answer due
	logic       wr;       // Write takes effect now
	logic       rd;       // Read data is prepared now
	logic       mapped;   // Index names a register
	logic       wr_lo;    // Write to low count byte
	logic       wr_hi;    // Write to high count byte
	logic       wr_cnt;   // Any count write
	logic       run;      // Run bit
	logic       cs;       // External source selected
	logic       byp;      // Unsynchronized counting
	logic       osc_en;   // Oscillator enabled
	logic       icyc_tick;// Instruction cycle enable
	logic       src_lvl;  // Selected external level
	logic       src_rise; // Rising edge on it
	logic       src_tick; // Selected source tick
	logic       adv;      // Counter advance
	logic       trig;     // Special event reset
	logic [7:0] rdv;      // Read value, low byte

	// Bus decode and control field aliases
	// Address bits 1:0 are ignored: each register is one aligned word
	always_comb begin
		idx    = paddr[9:2];
		mapped = hit(idx, `TMC_IDX_GCTL) | hit(idx, `TMC_IDX_FLAG)
		       | hit(idx, `TMC_IDX_CNT_LO) | hit(idx, `TMC_IDX_CNT_HI)
		       | hit(idx, `TMC_IDX_CTRL) | hit(idx, `TMC_IDX_IEN);
		// One wait state: answer is a flop, set after setup
		// A write lands only at the edge at which ready stands high
		acc    = psel & penable & ~s_reg.pready;
		wr     = psel & penable & pwrite & s_reg.pready & mapped;
		rd     = acc & ~pwrite;
		wr_lo  = wr & hit(idx, `TMC_IDX_CNT_LO);
		wr_hi  = wr & hit(idx, `TMC_IDX_CNT_HI);
		wr_cnt = wr_lo | wr_hi;
		run    = s_reg.ctrl[`TMC_CTRL_RUN];
		cs     = s_reg.ctrl[`TMC_CTRL_CS];
		byp    = s_reg.ctrl[`TMC_CTRL_BYP];
		osc_en = s_reg.ctrl[`TMC_CTRL_OSC];
	end

	// Count path: source select, prescale, trigger
	// Limitation: the unsynchronized path still passes the pin flops,
	// so edges are seen late and the pin must toggle slower than pclk
	always_comb begin
		// Divider phase is not cleared by writes or triggers
		// Core clock stops in sleep, so does the instruction cycle
		icyc_tick = (s_reg.icyc == `TMC_ICYC_LAST) & ~sleep_mode;
		// Oscillator owns the shared pin when enabled
		src_lvl   = osc_en ? s_reg.x_s2 : s_reg.e_s2;
		src_rise  = src_lvl & ~s_reg.src_prev;
		if (cs) begin
			// Synchronized edges need the core clock running
			src_tick = src_rise & (byp | ~sleep_mode);
		end else begin
			src_tick = icyc_tick;
		end
		adv  = run & src_tick
		     & ((s_reg.psc & psc_mask(s_reg.ctrl[`TMC_CTRL_PSHI:`TMC_CTRL_PSLO]))
		        == psc_mask(s_reg.ctrl[`TMC_CTRL_PSHI:`TMC_CTRL_PSLO]));
		// Match against the pair makes it the period
		// Not gated by the run bit; held off without synchronization,
		// where a reset could land on a half-seen pin edge
		trig = (compare_unit_mode_select == `TMC_MODE_SPEV)
		     & (s_reg.count == compare_value_pair)
		     & ~(cs & byp);
	end

	// Read multiplexer
	// Bits that a register does not hold read as zero
	always_comb begin
		rdv = 8'h00;
		case (idx)
			`TMC_IDX_GCTL: begin
				rdv[`TMC_GCTL_GIE:`TMC_GCTL_PEIE] = s_reg.gctl;
			end
			`TMC_IDX_FLAG: begin
				rdv[`TMC_FLAG_BIT] = s_reg.flag;
			end
			`TMC_IDX_CNT_LO: begin
				rdv = s_reg.count[7:0];
			end
			`TMC_IDX_CNT_HI: begin
				rdv = s_reg.count[15:8];
			end
			`TMC_IDX_CTRL: begin
				// Top two bits stay zero
				rdv = {2'h0, s_reg.ctrl};
			end
			`TMC_IDX_IEN: begin
				rdv[`TMC_FLAG_BIT] = s_reg.ien;
			end
			default: begin
				rdv = 8'h00;
			end
		endcase
	end

	// Next state
	// Later assignments win: the order below is the priority order
	always_comb begin
		s_next = s_reg;
		// Instruction cycle divider freezes in sleep
		if (!sleep_mode) begin
			s_next.icyc = s_reg.icyc + 2'h1;
		end
		// Two-flop synchronizers for both pins
		// Only the second stage is read by the edge logic
		s_next.e_s1     = external_count_input;
		s_next.e_s2     = s_reg.e_s1;
		s_next.x_s1     = crystal_input_pin;
		s_next.x_s2     = s_reg.x_s1;
		s_next.src_prev = src_lvl;
		// Prescaler steps on each gated source tick
		if (run & src_tick) begin
			s_next.psc = s_reg.psc + 3'h1;
		end
		// Counter: write, then trigger, then advance
		// A count write leaves the prescaler phase as it was
		if (trig) begin
			// Reset leaves the overflow flag alone
			s_next.count = `TMC_CNT_RST;
			s_next.psc   = 3'h0;
		end else if (adv) begin
			s_next.count = s_reg.count + 16'h0001;
		end
		if (wr_lo) begin
			s_next.count[7:0] = pwdata[7:0];
		end
		if (wr_hi) begin
			s_next.count[15:8] = pwdata[7:0];
		end
		// Other register writes
		// Enables are single bits; the other bits of those registers stay clear
		if (wr & hit(idx, `TMC_IDX_CTRL)) begin
			s_next.ctrl = pwdata[`TMC_CTRL_W-1:0];
		end
		if (wr & hit(idx, `TMC_IDX_IEN)) begin
			s_next.ien = pwdata[`TMC_FLAG_BIT];
		end
		if (wr & hit(idx, `TMC_IDX_GCTL)) begin
			s_next.gctl = pwdata[`TMC_GCTL_GIE:`TMC_GCTL_PEIE];
		end
		// Flag: write one clears, a wrap in the same cycle wins
		if (wr & hit(idx, `TMC_IDX_FLAG) & pwdata[`TMC_FLAG_BIT]) begin
			s_next.flag = 1'b0;
		end
		if (adv & ~trig & ~wr_cnt & (s_reg.count == `TMC_CNT_MAX)) begin
			s_next.flag = 1'b1;
		end
		// Interrupt needs flag, enable and both global enables
		s_next.irq = s_next.flag & s_next.ien
		           & s_next.gctl[`TMC_GCTL_GIE - `TMC_GCTL_PEIE]
		           & s_next.gctl[0];
		// Trigger outputs are one-cycle pulses, except with a zero compare value, where they stay high
		s_next.trig = trig & ~wr_cnt;
		s_next.conv = trig & ~wr_cnt & adc_enable;
		// Amplifier inverts the crystal input while enabled
		s_next.osc_out  = osc_en & ~s_reg.x_s2;
		s_next.osc_oe_n = ~osc_en;
		// Bus answer: ready one cycle in the access phase
		// Read data is latched a cycle early and held until the next read
		s_next.pready  = acc;
		s_next.pslverr = acc & ~mapped;
		if (rd) begin
			s_next.prdata = {24'h000000, rdv};
		end
	end

	// State register
	// Reset loads constants only; the amplifier enable starts inactive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg          <= '0;
			s_reg.count    <= `TMC_CNT_RST;
			s_reg.ctrl     <= `TMC_CTRL_RST;
			s_reg.osc_oe_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state flops
	// No output is combinational, so the bus never sees a glitch
	assign prdata              = s_reg.prdata;
	assign pready              = s_reg.pready;
	assign pslverr             = s_reg.pslverr;
	assign irq                 = s_reg.irq;
	assign conversion_start    = s_reg.conv;
	assign special_trigger     = s_reg.trig;
	assign crystal_output_pin  = s_reg.osc_out;
	assign crystal_output_oe_n = s_reg.osc_oe_n;

	// Checks
	// They watch registered state, outputs, bus inputs and decode terms; reset disables all of them
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_ctrl_top_zero: assert property (
		(rd & hit(idx, `TMC_IDX_CTRL)) |=> (prdata[31:6] == 26'h0)
	) else $error("control read shows upper bits");

	chk_run_stop: assert property (
		(!run & !wr_cnt & !trig) |=> $stable(s_reg.count)
	) else $error("counter moved while stopped");

	chk_wrap_flag: assert property (
		(adv & !trig & !wr & s_reg.count == `TMC_CNT_MAX)
		|=> (s_reg.count == `TMC_CNT_RST) && s_reg.flag
	) else $error("wrap did not set flag");

	chk_trig_noflag: assert property (
		(trig & !wr) |=> (s_reg.count == `TMC_CNT_RST)
		&& (s_reg.flag == $past(s_reg.flag))
	) else $error("trigger reset wrong");

	chk_write_wins: assert property (
		(wr_lo & trig) |=> (s_reg.count[7:0] == $past(pwdata[7:0]))
	) else $error("trigger beat a count write");

	chk_irq_mask: assert property (
		!s_reg.ien |-> !irq
	) else $error("masked interrupt raised");

	chk_conv_pulse: assert property (
		(trig & !wr_cnt & adc_enable) |=> conversion_start ##1 !conversion_start
	) else $error("conversion start not pulsed");

	chk_icyc_rate: assert property (
		(adv & !cs) |=> !adv [*3]
	) else $error("timer faster than instruction cycle");

	chk_bus_answer: assert property (
		(psel & !penable) ##1 (psel & penable) |=> pready ##1 !pready
	) else $error("bus answer timing wrong");

	chk_flag_sticky: assert property (
		(s_reg.flag & !(wr & hit(idx, `TMC_IDX_FLAG) & pwdata[`TMC_FLAG_BIT]))
		|=> s_reg.flag
	) else $error("overflow flag dropped by itself");

	chk_flag_clear: assert property (
		(wr & hit(idx, `TMC_IDX_FLAG) & pwdata[`TMC_FLAG_BIT]
		 & !(adv & s_reg.count == `TMC_CNT_MAX)) |=> !s_reg.flag
	) else $error("overflow flag not cleared by write");

	chk_osc_drive: assert property (
		osc_en |=> !crystal_output_oe_n
	) else $error("oscillator amplifier not driving");

	chk_osc_quiet: assert property (
		!osc_en |=> crystal_output_oe_n && !crystal_output_pin
	) else $error("oscillator amplifier not shut off");

	chk_trig_pulse: assert property (
		(trig & !wr_cnt) |=> special_trigger
	) else $error("trigger reset not reported");

	chk_bus_error: assert property (
		(acc & !mapped) |=> pready && pslverr
	) else $error("unmapped access not refused");

	chk_rdata_hold: assert property (
		!rd |=> $stable(prdata)
	) else $error("read data changed without a read");

	chk_ready_pulse: assert property (
		pready |=> !pready
	) else $error("ready stood longer than one cycle");

	chk_rdata_upper: assert property (
		pready |-> (prdata[31:8] == 24'h000000)
	) else $error("read data upper bytes not zero");

endmodule : tmc_timer
`default_nettype wire

// [pkg/tmc_defines.svh]
// Constants of the sixteen-bit timer/counter block
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
// Register indices; byte address is four times the index
`define TMC_IDX_GCTL   8'h0b
`define TMC_IDX_FLAG   8'h0c
`define TMC_IDX_CNT_LO 8'h0e
`define TMC_IDX_CNT_HI 8'h0f
`define TMC_IDX_CTRL   8'h10
`define TMC_IDX_IEN    8'h8c
// Control register fields
`define TMC_CTRL_RUN   0
`define TMC_CTRL_CS    1
`define TMC_CTRL_BYP   2
`define TMC_CTRL_OSC   3
`define TMC_CTRL_PSLO  4
`define TMC_CTRL_PSHI  5
`define TMC_CTRL_W     6
// Global control fields kept in bits 7:6
`define TMC_GCTL_PEIE  6
`define TMC_GCTL_GIE   7
// Flag and enable sit in bit 0
`define TMC_FLAG_BIT   0
// Reset values
`define TMC_CTRL_RST   6'h00
`define TMC_CNT_RST    16'h0000
`define TMC_CNT_MAX    16'hffff
// Compare unit special event trigger encoding
`define TMC_MODE_SPEV  4'hb
// Instruction cycle is four system clocks
`define TMC_ICYC_LAST  2'h3
`endif

// [pkg/tmc_pkg.sv]
// Types of the sixteen-bit timer/counter block
package tmc_pkg;
	// Whole state of the timer module
	typedef struct packed {
		logic [1:0]  icyc;     // Instruction cycle divider
		logic        e_s1;     // External pin sync stage 1
		logic        e_s2;     // External pin sync stage 2
		logic        x_s1;     // Crystal pin sync stage 1
		logic        x_s2;     // Crystal pin sync stage 2
		logic        src_prev; // Previous selected level
		logic [2:0]  psc;      // Input prescaler
		logic [15:0] count;    // Counter value
		logic [5:0]  ctrl;     // Control bits 5:0
		logic        flag;     // Overflow flag
		logic        ien;      // Overflow enable
		logic [1:0]  gctl;     // Global enables
		logic        pready;   // Bus answer
		logic        pslverr;  // Bus error
		logic [31:0] prdata;   // Read data
		logic        irq;      // Interrupt line
		logic        conv;     // Conversion start
		logic        trig;     // Trigger seen
		logic        osc_out;  // Amplifier output
		logic        osc_oe_n; // Amplifier enable
	} tmc_state_t;
endpackage : tmc_pkg

// [verif/tmc_far_model.sv]
// Far-side model: external count clock and crystal oscillator
`timescale 1ns/10ps
`default_nettype none
module tmc_far_model (
	input  wire logic pclk,
	input  wire logic crystal_output_oe_n,
	output logic      external_count_input,
	output logic      crystal_input_pin
);
	int xdiv; // Crystal half-period counter
	initial begin
		external_count_input = 1'b0;
		crystal_input_pin = 1'b0;
		xdiv = 0;
	end
	// External clock: exact pulse count, low between bursts
	task automatic ext_pulses(input int n);
		repeat (n) begin
			repeat (8) @(posedge pclk);
			external_count_input <= 1'b1;
			repeat (8) @(posedge pclk);
			external_count_input <= 1'b0;
		end
	endtask : ext_pulses
	// Swings only while the amplifier drives; sleep does not stop it
	always @(posedge pclk) begin
		xdiv <= crystal_output_oe_n ? 0 : (xdiv + 1) % 12;
		if (!crystal_output_oe_n && xdiv == 11) begin
			crystal_input_pin <= ~crystal_input_pin;
		end
	end
endmodule : tmc_far_model
`default_nettype wire

// [verif/tb_sixteen_bit_timer_counter.sv]
// Self-checking bench of the timer/counter over APB
`timescale 1ns/10ps
`include "tmc_defines.svh"
`default_nettype none
module tb_sixteen_bit_timer_counter;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sleep_mode;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        ext_in, xtal_in, xtal_out, xtal_oe_n, adc_enable, conv, trig, err_seen;
	logic [3:0]  mode;
	logic [15:0] cmp, c, c2;
	logic [7:0]  r;
	int          error_cnt, samples_checked, cyc, t1;
	tmc_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .sleep_mode(sleep_mode), .external_count_input(ext_in),
		.crystal_input_pin(xtal_in), .crystal_output_pin(xtal_out),
		.crystal_output_oe_n(xtal_oe_n),
		.compare_unit_mode_select(mode), .compare_value_pair(cmp), .adc_enable(adc_enable),
		.conversion_start(conv), .special_trigger(trig));
	tmc_far_model i_far (.pclk(pclk), .crystal_output_oe_n(xtal_oe_n),
		.external_count_input(ext_in), .crystal_input_pin(xtal_in));
	// 125 MHz clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata[7:0];
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] x;
		apb(1'b1, idx, d, x);
	endtask : wr
	task automatic get_cnt(output logic [15:0] v);
		apb(1'b0, `TMC_IDX_CNT_LO, 8'h00, v[7:0]);
		apb(1'b0, `TMC_IDX_CNT_HI, 8'h00, v[15:8]);
	endtask : get_cnt
	task automatic clr_cnt(input logic [7:0] ctl);
		wr(`TMC_IDX_CNT_LO, 8'h00);
		wr(`TMC_IDX_CNT_HI, 8'h00);
		wr(`TMC_IDX_CTRL, ctl);
	endtask : clr_cnt
	// Waits for the trigger pulse, bounded
	task automatic wait_trig();
		int n;
		n = 0;
		do @(posedge pclk); while (trig !== 1'b1 && ++n < 200);
		check("conv", {15'h0, conv}, 16'h1);
	endtask : wait_trig
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		{presetn, psel, penable, pwrite, sleep_mode, adc_enable} = '0;
		{paddr, pwdata, mode, cmp, cyc, error_cnt, samples_checked} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Upper control bits read zero; unmapped index refused
		wr(`TMC_IDX_CTRL, 8'hff);
		apb(1'b0, `TMC_IDX_CTRL, 8'h00, r);
		check("ctrl", {8'h0, r}, 16'h003f);
		wr(`TMC_IDX_CTRL, 8'h00);
		apb(1'b0, 8'h20, 8'h00, r);
		check("slverr", {15'h0, err_seen}, 16'h1);
		$display("test regs done");
		// Every prescale code in timer mode, then stop holds the count
		for (int p = 0; p < 4; p++) begin
			clr_cnt({2'b00, p[1:0], 4'b0001});
			repeat (256) @(posedge pclk);
			wr(`TMC_IDX_CTRL, 8'h00);
			get_cnt(c);
			check("rate", {15'h0, c >= (16'd64 >> p) && c <= (16'd66 >> p) + 1}, 16'h1);
			get_cnt(c2);
			check("stop", c2, c);
		end
		$display("test prescale done");
		// Wrap sets sticky flag; enable masks the interrupt
		wr(`TMC_IDX_IEN, 8'h01);
		wr(`TMC_IDX_GCTL, 8'hc0);
		wr(`TMC_IDX_CNT_LO, 8'hfc);
		wr(`TMC_IDX_CNT_HI, 8'hff);
		wr(`TMC_IDX_CTRL, 8'h01);
		repeat (40) @(posedge pclk);
		wr(`TMC_IDX_CTRL, 8'h00);
		get_cnt(c);
		check("wrap", {15'h0, c < 16'h0010}, 16'h1);
		apb(1'b0, `TMC_IDX_FLAG, 8'h00, r);
		check("flag", {8'h0, r}, 16'h0001);
		check("irq", {15'h0, irq}, 16'h1);
		wr(`TMC_IDX_IEN, 8'h00);
		@(posedge pclk);
		check("irq", {15'h0, irq}, 16'h0);
		wr(`TMC_IDX_FLAG, 8'h01);
		apb(1'b0, `TMC_IDX_FLAG, 8'h00, r);
		check("flag", {8'h0, r}, 16'h0000);
		$display("test overflow done");
		// Special event trigger: compare value acts as period
		mode <= `TMC_MODE_SPEV;
		cmp <= 16'h0010;
		adc_enable <= 1'b1;
		clr_cnt(8'h01);
		wait_trig();
		t1 = cyc;
		wait_trig();
		check("period", {15'h0, (cyc - t1) >= 64 && (cyc - t1) <= 72}, 16'h1);
		wr(`TMC_IDX_CTRL, 8'h00);
		apb(1'b0, `TMC_IDX_FLAG, 8'h00, r);
		check("flag", {8'h0, r}, 16'h0000);
		// Zero count against a zero compare keeps the trigger standing;
		// a count write that meets it must still land
		adc_enable <= 1'b0;
		cmp <= 16'h0000;
		wr(`TMC_IDX_CNT_LO, 8'h00);
		@(posedge pclk);
		check("trig_on", {15'h0, trig}, 16'h1);
		check("conv_off", {15'h0, conv}, 16'h0);
		wr(`TMC_IDX_CNT_LO, 8'h33);
		mode <= 4'h0;
		get_cnt(c);
		check("write_wins", c, 16'h0033);
		$display("test trigger done");
		// External pin, synchronized and not
		for (int b = 0; b < 2; b++) begin
			clr_cnt(b ? 8'h07 : 8'h03);
			i_far.ext_pulses(5);
			repeat (8) @(posedge pclk);
			wr(`TMC_IDX_CTRL, 8'h00);
			get_cnt(c);
			check("ext", c, 16'h0005);
		end
		// Oscillator starts, runs through sleep, stops
		clr_cnt(8'h0e);
		repeat (100) @(posedge pclk);
		check("osc_on", {15'h0, xtal_oe_n}, 16'h0);
		wr(`TMC_IDX_CTRL, 8'h0f);
		sleep_mode <= 1'b1;
		repeat (240) @(posedge pclk);
		sleep_mode <= 1'b0;
		wr(`TMC_IDX_CTRL, 8'h0e);
		get_cnt(c);
		check("sleep", {15'h0, c >= 16'd8 && c <= 16'd12}, 16'h1);
		wr(`TMC_IDX_CTRL, 8'h00);
		@(posedge pclk);
		check("osc_off", {15'h0, xtal_oe_n}, 16'h1);
		check("osc_out", {15'h0, xtal_out}, 16'h0);
		$display("test external done");
		end_sim();
	end
endmodule : tb_sixteen_bit_timer_counter
`default_nettype wire
